// File: include/lane_map_regs.svh
`ifndef LANE_MAP_REGS_SVH
`define LANE_MAP_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define LM_CTRL_OFS      4'h0
`define LM_TEST_OFS      4'h4
`define LM_STAT_OFS      4'h8
`define LM_FCNT_OFS      4'hC

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define LM_CTRL_RST      16'h180E
`define LM_TEST_RST      3'h0

// ----------------------------------------------------------------------------
// Status field positions
// ----------------------------------------------------------------------------
`define LM_STAT_EN_LSB   0
`define LM_STAT_PD_BIT   8
`define LM_STAT_ST_LSB   9
`define LM_STAT_NE_BIT   11
`define LM_STAT_FULL_BIT 12
`define LM_STAT_ALT_BIT  13
`define LM_STAT_UNDR_BIT 14

// ----------------------------------------------------------------------------
// Link modes, geometry and pattern timing
// ----------------------------------------------------------------------------
`define LM_MODE_14       5'h0E
`define LM_MODE_15       5'h0F
`define LM_LANES         8
`define LM_SAMPLES       16
`define LM_SAMPLE_W      9
`define LM_PAD_W         3
`define LM_WORD_W        24
`define LM_PRBS_W        31
`define LM_FIFO_DEPTH    8
`define LM_CLK_STEP      4'h8

`endif

// File: include/lane_map_pkg.sv
`default_nettype none

`include "lane_map_regs.svh"

package lane_map_pkg;

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    TS_OFF    = 3'b000,
    TS_PRBS7  = 3'b001,
    TS_PRBS9  = 3'b010,
    TS_PRBS15 = 3'b011,
    TS_PRBS23 = 3'b100,
    TS_PRBS31 = 3'b101,
    TS_CLOCK  = 3'b110
  } test_sel_t;

  typedef enum logic [1:0] {
    ST_OFF  = 2'b00,
    ST_RUN  = 2'b01,
    ST_TEST = 2'b10,
    ST_PD   = 2'b11
  } link_state_t;

  typedef struct packed {
    logic [2:0] rsvd;
    logic [1:0] channel_pair_enable;
    logic       fec;
    logic       link_en;
    logic       mode_pd;
    logic       alternate_lane_select;
    logic [1:0] lane_cnt;
    logic [4:0] link_mode_select;
  } ctrl_t;

  typedef logic [`LM_SAMPLES-1:0][`LM_SAMPLE_W-1:0] sample_frame_t;
  typedef logic [`LM_LANES-1:0][`LM_WORD_W-1:0]     lane_words_t;

  typedef struct packed {
    lane_words_t          data;
    logic [`LM_LANES-1:0] lane_en;
    logic                 valid;
    logic [2:0]           pattern;
    logic                 fec;
  } lane_bus_t;

  typedef struct packed {
    logic [`LM_PRBS_W-1:0] st;
    logic [`LM_WORD_W-1:0] word;
  } prbs_res_t;

  // --------------------------------------------------------------------------
  // Pattern generators, first bit on the wire in the word's MSB
  // --------------------------------------------------------------------------
  function automatic prbs_res_t prbs24(input logic [`LM_PRBS_W-1:0] s_in,
                                       input logic [2:0]            sel);
    prbs_res_t             r;
    logic [`LM_PRBS_W-1:0] s;
    logic                  b;
    r = '0;
    s = s_in;
    for (int i = 0; i < `LM_WORD_W; i++) begin
      case (sel)
        TS_PRBS7:  b = s[5] ^ s[6];
        TS_PRBS9:  b = s[4] ^ s[8];
        TS_PRBS15: b = s[13] ^ s[14];
        TS_PRBS23: b = s[17] ^ s[22];
        default:   b = s[27] ^ s[30];
      endcase
      s = {s[`LM_PRBS_W-2:0], b};
      r.word[`LM_WORD_W-1-i] = b;
    end
    r.st = s;
    return r;
  endfunction

  function automatic logic [`LM_WORD_W-1:0] clk24(input logic [3:0] phase);
    logic [`LM_WORD_W-1:0] w;
    logic [3:0]            p;
    w = '0;
    for (int i = 0; i < `LM_WORD_W; i++) begin
      p = phase + 4'(i);
      w[`LM_WORD_W-1-i] = ~p[3];
    end
    return w;
  endfunction

endpackage

`default_nettype wire

// File: design/lane_mapper.sv

`default_nettype none

`include "lane_map_regs.svh"

// ----------------------------------------------------------------------------
// Sample frame FIFO
// ----------------------------------------------------------------------------
module lane_fifo #(
  parameter int WIDTH = 144,
  parameter int DEPTH = 8
) (
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
    logic                        in_ready;
    logic                        out_valid;
  } fifo_state_t;

  fifo_state_t st_r;
  fifo_state_t st_nxt;
  logic        push;
  logic        pop;

  assign push      = in_valid && st_r.in_ready;
  assign pop       = out_ready && st_r.out_valid;
  assign in_ready  = st_r.in_ready;
  assign out_valid = st_r.out_valid;
  assign out_data  = st_r.mem[st_r.rp];

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wp] = in_data;
      st_nxt.wp           = st_r.wp + AW'(1);
    end
    if (pop) begin
      st_nxt.rp = st_r.rp + AW'(1);
    end
    st_nxt.cnt       = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    // Flags are registered so the source and sink see flop outputs
    st_nxt.in_ready  = st_nxt.cnt != (AW+1)'(DEPTH);
    st_nxt.out_valid = st_nxt.cnt != '0;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_r          <= '0;
      st_r.in_ready <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule // lane_fifo

// ----------------------------------------------------------------------------
// Lane mapper and serializer test pattern source
// ----------------------------------------------------------------------------
module lane_mapper
  import lane_map_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          resetn,
  input  wire logic [3:0]    address,
  input  wire logic          read,
  input  wire logic          write,
  input  wire logic [3:0]    byteenable,
  input  wire logic [31:0]   writedata,
  output logic [31:0]        readdata,
  output logic               waitrequest,
  input  wire logic          power_down_input,
  input  wire sample_frame_t samp_data,
  input  wire logic          samp_valid,
  output logic               samp_ready,
  output lane_bus_t          lane_out
);

  typedef struct packed {
    ctrl_t                                ctrl;
    logic [2:0]                           test_sel;
    logic                                 pd_meta;
    logic                                 pd_sync;
    link_state_t                          lstate;
    logic                                 waitreq;
    logic [31:0]                          rdata;
    logic [`LM_LANES-1:0][`LM_PRBS_W-1:0] prbs;
    logic [3:0]                           clk_phase;
    logic                                 underrun;
    logic [31:0]                          frames;
    lane_bus_t                            out;
  } mapper_state_t;

  mapper_state_t  st_r;
  mapper_state_t  st_nxt;
  sample_frame_t  fifo_data;
  logic           fifo_valid;
  logic           fifo_ready;
  logic           pwr_dn;
  lane_words_t    map14_w;
  lane_words_t    map15_w;
  prbs_res_t [`LM_LANES-1:0] prbs_w;

  // --------------------------------------------------------------------------
  // Frame buffer
  // --------------------------------------------------------------------------
  lane_fifo #(
    .WIDTH ($bits(sample_frame_t)),
    .DEPTH (`LM_FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .resetn    (resetn),
    .in_data   (samp_data),
    .in_valid  (samp_valid),
    .in_ready  (samp_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready)
  );

  assign pwr_dn     = st_r.pd_sync | st_r.ctrl.mode_pd;
  // Frames stay buffered through test or power-down; the receiver must relink
  assign fifo_ready = (st_r.lstate == ST_RUN) && !pwr_dn;

  // --------------------------------------------------------------------------
  // Per-lane mapping and pattern generators
  // --------------------------------------------------------------------------
  for (genvar g = 0; g < `LM_LANES; g++) begin : g_lane
    localparam int C14 = (g / 2) * 4 + (g % 2);
    localparam int C15 = (g / 4) * 8 + (g % 4);
    assign map14_w[g] = {fifo_data[C14], {`LM_PAD_W{1'b0}},
                         fifo_data[C14+2], {`LM_PAD_W{1'b0}}};
    assign map15_w[g] = {fifo_data[C15], {`LM_PAD_W{1'b0}},
                         fifo_data[C15+4], {`LM_PAD_W{1'b0}}};
    assign prbs_w[g]  = prbs24(st_r.prbs[g], st_r.test_sel);
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    logic                 alt_eff;
    logic                 mode_ok;
    logic                 is_prbs;
    logic                 test_on;
    logic [`LM_LANES-1:0] base_mask;
    logic [`LM_LANES-1:0] log_mask;
    logic [`LM_LANES-1:0] phys_mask;
    lane_words_t          log_data;
    lane_words_t          phys_data;
    logic [31:0]          stat;
    ctrl_t                cnew;
    alt_eff   = 1'b0;
    mode_ok   = 1'b0;
    is_prbs   = 1'b0;
    test_on   = 1'b0;
    base_mask = '0;
    log_mask  = '0;
    phys_mask = '0;
    log_data  = '0;
    phys_data = '0;
    stat      = '0;
    cnew      = st_r.ctrl;
    st_nxt    = st_r;

    // Power-down pin, two flops before use
    st_nxt.pd_meta = power_down_input;
    st_nxt.pd_sync = st_r.pd_meta;

    // Lanes powered follow the link mode, whatever the test
    case (st_r.ctrl.lane_cnt)
      2'b01:   base_mask = 8'h0F;
      2'b10:   base_mask = 8'h03;
      default: base_mask = 8'hFF;
    endcase
    mode_ok  = (st_r.ctrl.link_mode_select == `LM_MODE_14) ||
               (st_r.ctrl.link_mode_select == `LM_MODE_15);
    log_mask = mode_ok ? base_mask & {{4{st_r.ctrl.channel_pair_enable[1]}},
                                      {4{st_r.ctrl.channel_pair_enable[0]}}}
                       : '0;
    alt_eff   = st_r.ctrl.alternate_lane_select &&
                (st_r.ctrl.lane_cnt inside {2'b01, 2'b10});
    phys_mask = alt_eff ? {log_mask[3:0], 4'h0} : log_mask;
    log_data  = (st_r.ctrl.link_mode_select == `LM_MODE_15) ? map15_w : map14_w;
    phys_data = alt_eff ? {log_data[3:0], {4{24'h00_0000}}} : log_data;

    is_prbs = (st_r.test_sel >= TS_PRBS7) && (st_r.test_sel <= TS_PRBS31);
    test_on = is_prbs || (st_r.test_sel == TS_CLOCK);

    // Link state
    if (pwr_dn) begin
      st_nxt.lstate = ST_PD;
    end else if (test_on) begin
      st_nxt.lstate = ST_TEST;
    end else if (st_r.ctrl.link_en) begin
      st_nxt.lstate = ST_RUN;
    end else begin
      st_nxt.lstate = ST_OFF;
    end

    // Generators advance only while a test runs; otherwise hold a seed
    for (int k = 0; k < `LM_LANES; k++) begin
      if (st_r.lstate == ST_TEST && is_prbs) begin
        st_nxt.prbs[k] = prbs_w[k].st;
      end else begin
        st_nxt.prbs[k] = 31'(k + 1);
      end
    end
    if (st_r.lstate == ST_TEST && st_r.test_sel == TS_CLOCK) begin
      st_nxt.clk_phase = st_r.clk_phase + `LM_CLK_STEP;
    end else begin
      st_nxt.clk_phase = 4'h0;
    end

    // Lane outputs
    st_nxt.out.lane_en = pwr_dn ? '0 : phys_mask;
    st_nxt.out.fec     = st_r.ctrl.fec;
    st_nxt.out.valid   = 1'b0;
    st_nxt.out.pattern = TS_OFF;
    st_nxt.out.data    = '0;
    if (!pwr_dn) begin
      case (st_r.lstate)
        ST_RUN: begin
          if (fifo_valid) begin
            st_nxt.out.valid = 1'b1;
            st_nxt.frames    = st_r.frames + 32'h0000_0001;
            for (int k = 0; k < `LM_LANES; k++) begin
              st_nxt.out.data[k] = phys_mask[k] ? phys_data[k] : '0;
            end
          end else begin
            st_nxt.underrun = 1'b1;
          end
        end
        ST_TEST: begin
          st_nxt.out.pattern = st_r.test_sel;
          for (int k = 0; k < `LM_LANES; k++) begin
            if (!phys_mask[k]) begin
              st_nxt.out.data[k] = '0;
            end else if (st_r.test_sel == TS_CLOCK) begin
              st_nxt.out.data[k] = clk24(st_r.clk_phase);
            end else begin
              st_nxt.out.data[k] = prbs_w[k].word;
            end
          end
        end
        default: begin
        end
      endcase
    end

    // Status image
    stat[`LM_STAT_EN_LSB +: `LM_LANES] = st_r.out.lane_en;
    stat[`LM_STAT_PD_BIT]              = pwr_dn;
    stat[`LM_STAT_ST_LSB +: 2]         = st_r.lstate;
    stat[`LM_STAT_NE_BIT]              = fifo_valid;
    stat[`LM_STAT_FULL_BIT]            = !samp_ready;
    stat[`LM_STAT_ALT_BIT]             = alt_eff;
    stat[`LM_STAT_UNDR_BIT]            = st_r.underrun;

    // Avalon slave: waitrequest drops for one cycle, two cycles per access
    st_nxt.waitreq = !((read || write) && st_r.waitreq);
    if (read && st_r.waitreq) begin
      case (address)
        `LM_CTRL_OFS: st_nxt.rdata = {16'h0000, st_r.ctrl};
        `LM_TEST_OFS: st_nxt.rdata = {29'h0000_0000, st_r.test_sel};
        `LM_STAT_OFS: st_nxt.rdata = stat;
        `LM_FCNT_OFS: st_nxt.rdata = st_r.frames;
        default:      st_nxt.rdata = 32'h0000_0000;
      endcase
    end
    // Writes do not depend on power state, so settings persist
    if (write && !st_r.waitreq) begin
      case (address)
        `LM_CTRL_OFS: begin
          if (byteenable[0]) begin
            cnew[7:0] = writedata[7:0];
          end
          if (byteenable[1]) begin
            cnew[15:8] = writedata[15:8];
          end
          cnew.rsvd = 3'h0;
          if (cnew.channel_pair_enable == 2'b00) begin
            cnew.channel_pair_enable = st_r.ctrl.channel_pair_enable;
          end
          st_nxt.ctrl = cnew;
        end
        `LM_TEST_OFS: begin
          if (byteenable[0]) begin
            st_nxt.test_sel = writedata[2:0];
          end
        end
        `LM_STAT_OFS: begin
          // Write one to clear; a new underrun in the same cycle wins
          if (byteenable[1] && writedata[`LM_STAT_UNDR_BIT] &&
              !(st_r.lstate == ST_RUN && !pwr_dn && !fifo_valid)) begin
            st_nxt.underrun = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_r          <= '0;
      st_r.ctrl     <= `LM_CTRL_RST;
      st_r.test_sel <= `LM_TEST_RST;
      st_r.waitreq  <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign readdata    = st_r.rdata;
  assign waitrequest = st_r.waitreq;
  assign lane_out    = st_r.out;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  AST_PD_PIN_KILLS_LANES: assert property (
    power_down_input [*3] |=> (lane_out.lane_en == 8'h00) && !lane_out.valid)
    else $error("lanes still enabled during power-down");

  AST_ALT_UPPER_GROUP: assert property (
    (st_r.ctrl.alternate_lane_select && (st_r.ctrl.lane_cnt inside {2'b01, 2'b10}))
      |=> (lane_out.lane_en[3:0] == 4'h0))
    else $error("default lanes active while alternate selected");

  AST_ONE_GROUP_ONLY: assert property (
    (st_r.ctrl.lane_cnt inside {2'b01, 2'b10})
      |=> (lane_out.lane_en[3:0] == 4'h0) || (lane_out.lane_en[7:4] == 4'h0))
    else $error("both lane groups driven");

  AST_PAIR_NOT_ALL_OFF: assert property (
    (write && !waitrequest && address == `LM_CTRL_OFS && byteenable[1] &&
     writedata[12:11] == 2'b00)
      |=> (st_r.ctrl.channel_pair_enable == $past(st_r.ctrl.channel_pair_enable)))
    else $error("pair enable allowed to power down all channels");

  AST_PRBS7_TAPS: assert property (
    (lane_out.pattern == TS_PRBS7 && lane_out.lane_en[0])
      |-> (lane_out.data[0][16] == (lane_out.data[0][22] ^ lane_out.data[0][23])))
    else $error("PRBS7 recursion broken");

  AST_PRBS9_TAPS: assert property (
    (lane_out.pattern == TS_PRBS9 && lane_out.lane_en[0])
      |-> (lane_out.data[0][14] == (lane_out.data[0][19] ^ lane_out.data[0][23])))
    else $error("PRBS9 recursion broken");

  AST_PRBS15_23_TAPS: assert property (
    (lane_out.lane_en[0] &&
     (lane_out.pattern == TS_PRBS15 || lane_out.pattern == TS_PRBS23))
      |-> (lane_out.pattern == TS_PRBS15)
          ? (lane_out.data[0][8] == (lane_out.data[0][22] ^ lane_out.data[0][23]))
          : (lane_out.data[0][0] == (lane_out.data[0][18] ^ lane_out.data[0][23])))
    else $error("PRBS15 or PRBS23 recursion broken");

  AST_CLOCK_PATTERN: assert property (
    (lane_out.pattern == TS_CLOCK && lane_out.lane_en[0])
      |-> (lane_out.data[0][23:16] == lane_out.data[0][7:0]) &&
          ($countones(lane_out.data[0][23:8]) == 8))
    else $error("clock pattern malformed");

  AST_PAD_BITS_ZERO: assert property (
    lane_out.valid |-> (lane_out.data[0][14:12] == 3'b000) &&
                       (lane_out.data[0][2:0] == 3'b000) &&
                       (lane_out.data[7][2:0] == 3'b000))
    else $error("pad bits not zero");

  AST_MODE14_MAP: assert property (
    (fifo_ready && fifo_valid && st_r.ctrl.link_mode_select == `LM_MODE_14 &&
     !st_r.ctrl.alternate_lane_select && st_r.ctrl.channel_pair_enable[0] &&
     !st_r.ctrl.mode_pd)
      |=> (lane_out.data[0][23:15] == $past(fifo_data[0])) &&
          (lane_out.data[0][11:3] == $past(fifo_data[2])) &&
          (lane_out.data[1][23:15] == $past(fifo_data[1])))
    else $error("mode 14 lane map wrong");

  AST_MODE15_MAP: assert property (
    (fifo_ready && fifo_valid && st_r.ctrl.link_mode_select == `LM_MODE_15 &&
     st_r.ctrl.lane_cnt == 2'b00 && st_r.ctrl.channel_pair_enable == 2'b11)
      |=> (lane_out.data[1][23:15] == $past(fifo_data[1])) &&
          (lane_out.data[1][11:3] == $past(fifo_data[5])) &&
          (lane_out.data[4][23:15] == $past(fifo_data[8])))
    else $error("mode 15 lane map wrong");

endmodule // lane_mapper

`default_nettype wire

// File: testbench/lane_rx.sv
`default_nettype none
// ----------------------------------------------------------------------------
// Receiver model: logs frames, drops stale ones after the link returns
// ----------------------------------------------------------------------------
module lane_rx
  import lane_map_pkg::*;
#(
  parameter int DROP = 2
) (
  input  wire logic      clock,
  input  wire logic      resetn,
  input  wire logic      link_down,
  input  wire lane_bus_t lane_out,
  output int             frames,
  output lane_words_t    log_q [8]
);
  int drop_left;

  // Pipeline holds meaningless data after a power-down, so it is not logged
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      frames    <= 0;
      drop_left <= 0;
    end else if (link_down) begin
      drop_left <= DROP;
    end else if (lane_out.valid && drop_left > 0) begin
      drop_left <= drop_left - 1;
    end else if (lane_out.valid) begin
      log_q[frames % 8] <= lane_out.data;
      frames            <= frames + 1;
    end
  end
endmodule  // lane_rx
`default_nettype wire

// File: testbench/tb_top.sv
`default_nettype none
module tb_top
  import lane_map_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // --------------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------------
  logic          clock, resetn, read, write, waitrequest;
  logic          power_down_input, samp_valid, samp_ready, link_down;
  logic [3:0]    address, byteenable;
  logic [31:0]   writedata, readdata, rv;
  logic [47:0]   c;
  logic [23:0]   w0, w1;
  sample_frame_t samp_data;
  sample_frame_t fr [8];
  lane_bus_t     lane_out;
  lane_words_t   log_q [8];
  int            frames, num_errors, num_checks, base;
  int            ta [7] = '{0, 6, 5, 14, 18, 28, 0};
  int            tz [7] = '{0, 7, 9, 15, 23, 31, 0};
  lane_mapper i_dut (
    .clock(clock), .resetn(resetn), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .power_down_input(power_down_input),
    .samp_data(samp_data), .samp_valid(samp_valid), .samp_ready(samp_ready),
    .lane_out(lane_out)
  );
  lane_rx i_rx (
    .clock(clock), .resetn(resetn), .link_down(link_down), .lane_out(lane_out),
    .frames(frames), .log_q(log_q)
  );

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // --------------------------------------------------------------------------
  // Tasks and expectations
  // --------------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clock);
  endtask

  // Request held until waitrequest is seen low; only the watchdog ends a wait
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    address   <= a;
    writedata <= d;
    write     <= w;
    read      <= ~w;
    do begin
      @(posedge clock);
    end while (waitrequest !== 1'b0);
    rv = readdata;
    write <= 1'b0;
    read  <= 1'b0;
  endtask

  // Frame held until the buffer takes it; never withdrawn
  task automatic push(input sample_frame_t fd);
    @(posedge clock);
    samp_data  <= fd;
    samp_valid <= 1'b1;
    do begin
      @(posedge clock);
    end while (samp_ready !== 1'b1);
    samp_valid <= 1'b0;
  endtask

  task automatic wait_frames(input int t);
    int n;
    n = 0;
    while (frames < t && n < 300) begin
      @(posedge clock);
      n++;
    end
    chk("frames", frames, t);
  endtask

  function automatic logic [23:0] exp_word(sample_frame_t fd, bit m15, int l);
    int a;
    a = m15 ? (l / 4) * 8 + l % 4 : (l / 2) * 4 + l % 2;
    return {fd[a], 3'b000, fd[a + (m15 ? 4 : 2)], 3'b000};
  endfunction

  function automatic bit prbs_ok(logic [47:0] s, int a, int b);
    bit r;
    r = 1;
    for (int n = b; n < 48; n++) if (s[47-n] !== (s[47-n+a] ^ s[47-n+b])) r = 0;
    return r;
  endfunction

  // Inverted every 8 bits and few transitions: runs of exactly eight
  function automatic bit clk_ok(logic [47:0] s);
    int t;
    bit r;
    t = 0;
    r = 1;
    for (int n = 8; n < 48; n++) if (s[47-n] !== ~s[55-n]) r = 0;
    for (int n = 1; n < 48; n++) if (s[47-n] != s[48-n]) t++;
    return r && t <= 6;
  endfunction
  // --------------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 4'h0;
    byteenable = 4'hF;
    writedata = 32'h0000_0000;
    samp_data = '0;
    samp_valid = 1'b0;
    power_down_input = 1'b0;
    link_down = 1'b0;
    void'($urandom(32'hfbc8_9e89));
    tick(5);
    resetn <= 1'b1;
    bus(0, 4'h0, 0);
    chk("ctrl_reset", rv, 32'h0000_180E);
    bus(1, 4'h2, 32'hFFFF_FFFF);
    bus(0, 4'h2, 0);
    chk("unmapped", rv, 32'h0000_0000);
    bus(1, 4'h0, 32'h0000_040E);
    bus(0, 4'h0, 0);
    chk("pair_keep", rv, 32'h0000_1C0E);
    tick(3);
    chk("fec", lane_out.fec, 1);
    $display("test registers done");
    for (int m = 0; m < 2; m++) begin
      base = frames;
      for (int k = 0; k < 8; k++) begin
        for (int i = 0; i < 16; i++) fr[k][i] = 9'($urandom);
        if (k == 0) fr[k][0] = 9'h1FF;
        push(fr[k]);
      end
      tick(1);
      chk("full", samp_ready, 1'b0);
      bus(1, 4'h0, m ? 32'h0000_1A0F : 32'h0000_1A0E);
      wait_frames(base + 8);
      for (int k = 0; k < 8; k++)
        for (int l = 0; l < 8; l++)
          chk("lane", log_q[(base + k) % 8][l], exp_word(fr[k], m, l));
      bus(1, 4'h0, 32'h0000_180E);
    end
    bus(0, 4'hC, 0);
    chk("frames_sent", rv, 32'h0000_0010);
    bus(0, 4'h8, 0);
    chk("underrun", rv[14], 1'b1);
    bus(1, 4'h8, 32'h0000_4000);
    bus(0, 4'h8, 0);
    chk("underrun_clr", rv[14], 1'b0);
    $display("test mapping done");
    for (int s = 1; s <= 6; s++) begin
      bus(1, 4'h4, 32'(s));
      tick(4);
      w0 = lane_out.data[0];
      w1 = lane_out.data[1];
      @(posedge clock);
      c = {w0, lane_out.data[0]};
      chk("pattern", lane_out.pattern, s);
      chk("test_lanes", lane_out.lane_en, 8'hFF);
      if (s < 6) chk("phase", w0 !== w1, 1);
      if (s < 6) chk("prbs", prbs_ok(c, ta[s], tz[s]), 1);
      else chk("clock_pat", clk_ok(c), 1);
    end
    bus(1, 4'h4, 0);
    $display("test patterns done");
    bus(1, 4'h0, 32'h0000_1AAE);
    tick(4);
    chk("alt", lane_out.lane_en, 8'hF0);
    bus(1, 4'h0, 32'h0000_1A2E);
    tick(4);
    chk("default", lane_out.lane_en, 8'h0F);
    bus(1, 4'h0, 32'h0000_1A8E);
    tick(4);
    chk("alt_8lane", lane_out.lane_en, 8'hFF);
    $display("test lane groups done");
    power_down_input <= 1'b1;
    link_down <= 1'b1;
    tick(6);
    chk("pd_pin", lane_out.lane_en, 8'h00);
    bus(0, 4'h0, 0);
    chk("pd_keep", rv, 32'h0000_1A8E);
    power_down_input <= 1'b0;
    tick(6);
    link_down <= 1'b0;
    base = frames;
    for (int k = 0; k < 3; k++) begin
      for (int i = 0; i < 16; i++) fr[k][i] = 9'($urandom);
      push(fr[k]);
    end
    wait_frames(base + 1);
    chk("relink", log_q[base % 8][0], exp_word(fr[2], 0, 0));
    bus(1, 4'h0, 32'h0000_1B8E);
    tick(4);
    chk("pd_mode", lane_out.lane_en, 8'h00);
    $display("test power down done");
    wrap_up();
  end

  // Whole run is a few hundred cycles; this allows ample margin
  initial begin
    #1_000_000;
    num_errors++;
    wrap_up();
  end
endmodule  // tb_top
`default_nettype wire
